// ---- logic/plsp_regs.svh ----
// named constants for the programming launch and status port:
// register offsets, field positions, reset values and timing figures.
// assumes it is included by its bare name from the design files.
`ifndef PLSP_REGS_SVH
`define PLSP_REGS_SVH

// register byte offsets, low address byte only
`define PLSP_ADDR_CTRL       8'h00
`define PLSP_ADDR_STATUS     8'h04
`define PLSP_ADDR_TIMEOUT    8'h08
`define PLSP_ADDR_RUNCNT     8'h0C

// control register fields
`define PLSP_CTRL_TRIG_BIT   0
`define PLSP_CTRL_AUX_BIT    1
`define PLSP_TRIG_RST        1'b0
`define PLSP_AUX_RST         1'b1

// status register fields
`define PLSP_ST_IDLE_BIT     0
`define PLSP_ST_PASS_BIT     1
`define PLSP_ST_FAIL_BIT     2
`define PLSP_ST_ACTIVE_BIT   3
`define PLSP_ST_SUPPLY_BIT   4
`define PLSP_ST_PEND_BIT     5
`define PLSP_ST_STATE_LSB    8
`define PLSP_ST_STATE_MSB    9

// timeout and run counter
`define PLSP_CNT_W           16
`define PLSP_TIMEOUT_RST     16'h0000
`define PLSP_CNT_ZERO        16'h0000
`define PLSP_CNT_ONE         16'h0001

// ahb-lite encodings
`define PLSP_HTRANS_NONSEQ   2'h2
`define PLSP_HSIZE_WORD      3'h2
`define PLSP_HRESP_OKAY      1'b0
`define PLSP_WORD_ZERO       32'h0000_0000

// timing: millisecond tick for the result age counter
`define PLSP_CLK_HZ          50000000
`define PLSP_TICK_MS         1
`define PLSP_TICK_CYCLES     (`PLSP_CLK_HZ / 1000 * `PLSP_TICK_MS)

`endif

// ---- logic/plsp_pkg.sv ----
// types shared by the programming launch and status port files.
// assumes nothing beyond a systemverilog compiler.
package plsp_pkg;

  // port sequencer states
  typedef enum logic [1:0] {
    PLSP_IDLE   = 2'b00,
    PLSP_CLEAR  = 2'b01,
    PLSP_BUSY   = 2'b10,
    PLSP_REPORT = 2'b11
  } plsp_state_t;

  // counter word for timeout and run count
  typedef logic [15:0] plsp_count_t;

endpackage

// ---- logic/plsp_sync.sv ----
// three-stage input synchroniser with agreement filter.
// assumes async_i comes from a pin outside the clock domain.
`timescale 1ns/1ps

module plsp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic async_i,
  // clock domain side
  output logic      sync_o
);

  logic stage1;      // metastable stage, read by stage2 only
  logic stage2;      // second stage
  logic stage3;      // third stage
  logic next_sync;   // filtered value

  // the filtered value moves only once stages two and three agree
  always_comb begin
    next_sync = sync_o;
    if (stage2 == stage3) begin
      next_sync = stage3;
    end
  end

  // register chain, constant values under reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

endmodule

// ---- logic/plsp_port.sv ----
// programming launch and status port: pin-facing sequencer, result
// age timeout and an ahb-lite register slave.
// assumes a programming engine on the same clock that takes a one-cycle
// start pulse and answers with a one-cycle done pulse plus a pass flag,
// and pad cells that turn each output and enable into a pin level.
//
// How it works
// [RULE1] launch on falling edge, sense low, allowed
// [RULE2] port inputs ignored unless sense held low
// [RULE3] pass low after a successful completed run
// [RULE4] pass high when nothing good to report
// [RULE5] fail low after a failed completed run
// [RULE6] fail high when nothing bad to report
// [RULE7] ready low while idle and launchable
// [RULE8] ready high while a run executes
// [RULE9] outputs driven only with io supply present
// [RULE10] hard reset returns port to idle
// [RULE11] launch: pass and fail high, then busy
// [RULE12] completion: result first, then ready low
// [RULE13] launch edge latched so pulses are kept
// [RULE14] trigger allow bit: one enables, zero disables
// [RULE15] inputs synchronised; edges during runs ignored
// [RULE16] partner waits for idle, then for result
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "plsp_regs.svh"

module plsp_port
  import plsp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PLSP_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // control port pins, inputs
  input  wire logic        launch_n_i,
  input  wire logic        sense_n_i,
  input  wire logic        io_supply_ref_i,
  // control port pins, outputs; pass, fail and ready with enables
  output logic             pass_n_o,
  output logic             pass_oe_o,
  output logic             fail_n_o,
  output logic             fail_oe_o,
  output logic             ready_n_o,
  output logic             ready_oe_o,
  output logic             aux_supply_out_o,
  // programming engine
  output logic             run_start_o,
  input  wire logic        run_done_i,
  input  wire logic        run_pass_i
);

  // synchronised pins
  logic launch_s;       // filtered launch level, low active
  logic sense_s;        // filtered sense level, low active
  logic supply_s;       // filtered supply presence
  logic launch_prev;    // launch level one cycle ago

  // sequencer group
  plsp_state_t state;        // sequencer state
  plsp_state_t next_state;   // next sequencer state
  logic        pending;      // captured launch edge
  logic        next_pending;
  logic        next_pass_n;
  logic        next_fail_n;
  logic        next_ready_n;
  logic        next_start;
  logic        launch_fall;  // qualified falling edge this cycle

  // result age group
  plsp_count_t tick_cnt;       // divider toward the ms tick
  plsp_count_t next_tick_cnt;
  logic        tick;           // one-cycle ms enable
  plsp_count_t age;            // ms since the result was shown
  plsp_count_t next_age;
  logic        aged_out;       // result too old, withdraw it

  // register group
  logic        trig_allow;     // launch from the port allowed
  logic        next_trig_allow;
  logic        aux_en;         // aux supply output enable
  logic        next_aux_en;
  plsp_count_t timeout;        // result lifetime in ms, zero is forever
  plsp_count_t next_timeout;
  plsp_count_t run_cnt;        // completed runs
  plsp_count_t next_run_cnt;
  logic        wr_pend;        // write data phase due
  logic        next_wr_pend;
  logic [7:0]  wr_addr;        // address held for the data phase
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic        addr_ok;        // valid word access in address phase
  logic [31:0] status_word;    // live status view

  // pin synchronisers, launch and sense idle levels match the pull-ups, supply rests absent
  plsp_sync #(.RST_VAL(1'b1)) u_sync_launch ( // RULE15
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (launch_n_i),
    .sync_o  (launch_s)
  );

  plsp_sync #(.RST_VAL(1'b1)) u_sync_sense ( // RULE15
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (sense_n_i),
    .sync_o  (sense_s)
  );

  plsp_sync #(.RST_VAL(1'b0)) u_sync_supply (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (io_supply_ref_i),
    .sync_o  (supply_s)
  );

  // an edge counts only with sense low, allow set and the block idle;
  // pulses shorter than about two clocks are dropped by the filter
  always_comb begin
    launch_fall = launch_prev & ~launch_s; // RULE13
    launch_fall = launch_fall & ~sense_s; // RULE2
    launch_fall = launch_fall & trig_allow; // RULE1
    launch_fall = launch_fall & (state == PLSP_IDLE); // RULE15
  end

  // sequencer next values
  always_comb begin
    next_state   = state;
    next_pass_n  = pass_n_o;
    next_fail_n  = fail_n_o;
    next_ready_n = ready_n_o;
    next_start   = 1'b0;
    next_pending = pending | launch_fall; // RULE13
    case (state)
      PLSP_IDLE: begin
        if (aged_out) begin
          // stale result is withdrawn
          next_pass_n = 1'b1; // RULE4
          next_fail_n = 1'b1; // RULE6
        end
        if (pending) begin
          // clear the result before showing busy
          next_pending = launch_fall;
          next_pass_n  = 1'b1; // RULE11
          next_fail_n  = 1'b1; // RULE11
          next_state   = PLSP_CLEAR;
        end
      end
      PLSP_CLEAR: begin
        // one cycle later go busy and start the engine
        next_ready_n = 1'b1; // RULE8
        next_start   = 1'b1; // RULE1
        next_state   = PLSP_BUSY;
      end
      PLSP_BUSY: begin
        // result goes out first, ready follows a cycle later
        if (run_done_i) begin
          next_pass_n = ~run_pass_i; // RULE3
          next_fail_n = run_pass_i; // RULE5
          next_state  = PLSP_REPORT; // RULE12
        end
      end
      PLSP_REPORT: begin
        next_ready_n = 1'b0; // RULE12
        next_state   = PLSP_IDLE; // RULE7
      end
      default: begin
        next_state   = PLSP_IDLE;
        next_ready_n = 1'b0;
      end
    endcase
  end

  // sequencer registers; hard reset shows idle with no result
  always_ff @(posedge clock_i) begin
    if (rst_i) begin // RULE10
      state       <= PLSP_IDLE;
      pending     <= 1'b0;
      pass_n_o    <= 1'b1;
      fail_n_o    <= 1'b1;
      ready_n_o   <= 1'b0;
      run_start_o <= 1'b0;
      launch_prev <= 1'b1;
      pass_oe_o   <= 1'b0;
      fail_oe_o   <= 1'b0;
      ready_oe_o  <= 1'b0;
    end else begin
      state       <= next_state;
      pending     <= next_pending;
      pass_n_o    <= next_pass_n;
      fail_n_o    <= next_fail_n;
      ready_n_o   <= next_ready_n;
      run_start_o <= next_start;
      launch_prev <= launch_s;
      pass_oe_o   <= supply_s; // RULE9
      fail_oe_o   <= supply_s; // RULE9
      ready_oe_o  <= supply_s; // RULE9
    end
  end

  // ms divider and result age; age restarts whenever a result lands
  always_comb begin
    tick          = (tick_cnt == plsp_count_t'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? `PLSP_CNT_ZERO : tick_cnt + `PLSP_CNT_ONE;
    next_age      = age;
    aged_out      = 1'b0;
    if (state == PLSP_REPORT) begin
      next_age = `PLSP_CNT_ZERO;
    end else if (tick && (age != timeout)) begin
      next_age = age + `PLSP_CNT_ONE;
    end
    // zero timeout keeps a result forever
    if ((timeout != `PLSP_CNT_ZERO) && (age == timeout)) begin
      aged_out = 1'b1; // RULE4
    end
  end

  // age registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_cnt <= `PLSP_CNT_ZERO;
      age      <= `PLSP_CNT_ZERO;
    end else begin
      tick_cnt <= next_tick_cnt;
      age      <= next_age;
    end
  end

  // live status word for reads
  always_comb begin
    status_word = `PLSP_WORD_ZERO;
    status_word[`PLSP_ST_IDLE_BIT]   = ~ready_n_o;
    status_word[`PLSP_ST_PASS_BIT]   = ~pass_n_o;
    status_word[`PLSP_ST_FAIL_BIT]   = ~fail_n_o;
    status_word[`PLSP_ST_ACTIVE_BIT] = supply_s & ~sense_s;
    status_word[`PLSP_ST_SUPPLY_BIT] = supply_s;
    status_word[`PLSP_ST_PEND_BIT]   = pending;
    status_word[`PLSP_ST_STATE_MSB:`PLSP_ST_STATE_LSB] = state;
  end

  // bus next values: read data is picked in the address phase so the
  // slave needs no wait states; writes land in the data phase
  always_comb begin
    addr_ok = hsel_i & hready_i & (htrans_i == `PLSP_HTRANS_NONSEQ)
              & (hsize_i == `PLSP_HSIZE_WORD);
    next_wr_pend    = addr_ok & hwrite_i;
    next_wr_addr    = haddr_i[7:0];
    next_hrdata     = `PLSP_WORD_ZERO;
    next_trig_allow = trig_allow;
    next_aux_en     = aux_en;
    next_timeout    = timeout;
    next_run_cnt    = run_cnt;
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[7:0])
        `PLSP_ADDR_CTRL: begin
          next_hrdata[`PLSP_CTRL_TRIG_BIT] = trig_allow;
          next_hrdata[`PLSP_CTRL_AUX_BIT]  = aux_en;
        end
        `PLSP_ADDR_STATUS: begin
          next_hrdata = status_word;
        end
        `PLSP_ADDR_TIMEOUT: begin
          next_hrdata[`PLSP_CNT_W-1:0] = timeout;
        end
        `PLSP_ADDR_RUNCNT: begin
          next_hrdata[`PLSP_CNT_W-1:0] = run_cnt;
        end
        default: begin
          // unmapped reads return zero
          next_hrdata = `PLSP_WORD_ZERO;
        end
      endcase
    end
    if (wr_pend) begin
      case (wr_addr)
        `PLSP_ADDR_CTRL: begin
          next_trig_allow = hwdata_i[`PLSP_CTRL_TRIG_BIT]; // RULE14
          next_aux_en     = hwdata_i[`PLSP_CTRL_AUX_BIT];
        end
        `PLSP_ADDR_TIMEOUT: begin
          next_timeout = hwdata_i[`PLSP_CNT_W-1:0];
        end
        `PLSP_ADDR_RUNCNT: begin
          // any write clears the run count unless a completion lands in that cycle
          next_run_cnt = `PLSP_CNT_ZERO;
        end
        default: begin
          // status and unmapped writes are dropped
          next_timeout = timeout;
        end
      endcase
    end
    // a completion in the clearing cycle still counts
    if ((state == PLSP_BUSY) && run_done_i) begin
      next_run_cnt = run_cnt + `PLSP_CNT_ONE;
    end
  end

  // bus registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trig_allow       <= `PLSP_TRIG_RST;
      aux_en           <= `PLSP_AUX_RST;
      timeout          <= `PLSP_TIMEOUT_RST;
      run_cnt          <= `PLSP_CNT_ZERO;
      wr_pend          <= 1'b0;
      wr_addr          <= `PLSP_ADDR_CTRL;
      hrdata_o         <= `PLSP_WORD_ZERO;
      hreadyout_o      <= 1'b1;
      hresp_o          <= `PLSP_HRESP_OKAY;
      aux_supply_out_o <= 1'b0;
    end else begin
      trig_allow       <= next_trig_allow;
      aux_en           <= next_aux_en;
      timeout          <= next_timeout;
      run_cnt          <= next_run_cnt;
      wr_pend          <= next_wr_pend;
      wr_addr          <= next_wr_addr;
      hrdata_o         <= next_hrdata;
      hreadyout_o      <= 1'b1;
      hresp_o          <= `PLSP_HRESP_OKAY;
      aux_supply_out_o <= aux_en;
    end
  end

endmodule

// ---- tb/plsp_port_asserts.sv ----
// checker for the launch and status port, bound to plsp_port.
// assumes one clock domain and sight of the top module's ports only.
`timescale 1ns/1ps

module plsp_port_asserts (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // watched pins and engine handshake
  input wire logic sense_n_i,
  input wire logic io_supply_ref_i,
  input wire logic run_done_i,
  input wire logic run_pass_i,
  input wire logic pass_n_o,
  input wire logic pass_oe_o,
  input wire logic fail_n_o,
  input wire logic fail_oe_o,
  input wire logic ready_n_o,
  input wire logic ready_oe_o,
  input wire logic run_start_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic [3:0] sense_hi;      // cycles with sense released, saturating
  logic [3:0] next_sense_hi; // next count

  // count stops at 15 so it never wraps back under the limit
  always_comb begin
    next_sense_hi = sense_hi;
    if (rst_i || !sense_n_i) begin
      next_sense_hi = 4'h0;
    end else if (sense_hi != 4'hF) begin
      next_sense_hi = sense_hi + 4'h1;
    end
  end
  // register only
  always_ff @(posedge clock_i) begin
    sense_hi <= next_sense_hi;
  end

  // result shown first, idle one cycle later
  sequence s_pass_idle;
    !pass_n_o && fail_n_o ##1 !ready_n_o;
  endsequence
  sequence s_fail_idle;
    pass_n_o && !fail_n_o ##1 !ready_n_o;
  endsequence

  a_never_both: assert property (pass_n_o || fail_n_o)
    else $error("pass and fail low together");
  a_done_pass: assert property (ready_n_o && !run_start_o && run_done_i
    && run_pass_i |=> s_pass_idle) else $error("pass report wrong");
  a_done_fail: assert property (ready_n_o && !run_start_o && run_done_i
    && !run_pass_i |=> s_fail_idle) else $error("fail report wrong");
  a_clear_first: assert property ($rose(ready_n_o)
    |-> $past(pass_n_o) && $past(fail_n_o)) else $error("busy before clear");
  a_start_busy: assert property (run_start_o
    |-> ready_n_o && pass_n_o && fail_n_o) else $error("start not busy");
  a_busy_nostart: assert property (ready_n_o && $past(ready_n_o)
    |-> !run_start_o) else $error("start while busy");
  a_sense_gate: assert property (run_start_o |-> sense_hi < 4'hC)
    else $error("start with sense released");
  a_oe_off: assert property (!io_supply_ref_i [*6]
    |-> !pass_oe_o && !fail_oe_o && !ready_oe_o) else $error("driven unpowered");
  // reset clears the supply filter, so only count supply cycles after it
  a_oe_on: assert property ((io_supply_ref_i && !rst_i) [*6]
    |-> pass_oe_o && fail_oe_o && ready_oe_o) else $error("not driven");
endmodule

bind plsp_port plsp_port_asserts i_chk (.clock_i, .rst_i, .sense_n_i,
  .io_supply_ref_i, .run_done_i, .run_pass_i, .pass_n_o, .pass_oe_o,
  .fail_n_o, .fail_oe_o, .ready_n_o, .ready_oe_o, .run_start_o);

// ---- tb/plsp_ctl_model.sv ----
// outside controller that launches runs through the port pins.
// assumes the bench resolves pull-ups and calls these tasks after an edge.
`timescale 1ns/1ps

module plsp_ctl_model (
  // clock
  input  wire logic clock_i,
  // resolved ready pin
  input  wire logic ready_pin_i,
  // pins driven towards the port
  output logic      launch_n_o,
  output logic      sense_n_o
);
  int n; // bounded wait count; a lost answer must not hang us

  initial begin
    launch_n_o = 1'b1; // released pins rest at the pull-up level
    sense_n_o  = 1'b1;
  end

  // bare low pulse, no handshake, used to poke a busy port
  task automatic pulse(input int hold);
    launch_n_o <= 1'b0;
    repeat (hold) @(posedge clock_i);
    launch_n_o <= 1'b1;
  endtask

  // polite launch: idle first, then busy and back to idle
  task automatic launch(input int hold);
    n = 0;
    while (ready_pin_i && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    pulse(hold);
    n = 0;
    while (!ready_pin_i && n < 20) begin // refused launches never go busy
      @(posedge clock_i);
      n++;
    end
    n = 0;
    while (ready_pin_i && n < 200) begin
      @(posedge clock_i);
      n++;
    end
  endtask

  // select or release the port
  task automatic select(input logic on);
    sense_n_o <= !on;
  endtask
endmodule

// ---- tb/plsp_port_test.sv ----
// self-checking bench for plsp_port with a model controller and engine.
// assumes a short tick so result ageing fits in a short run.
`timescale 1ns/1ps

module plsp_port_test;
  import plsp_pkg::*;
  typedef struct {
    logic allow, on, pass;
    logic [31:0] runs;
    logic pass_n, fail_n;
  } plsp_row_t;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b1;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, q;
  logic hreadyout_o, hresp_o, launch_n_i, sense_n_i, aux_supply_out_o;
  logic io_supply_ref_i = 1'b1;
  logic pass_n_o, pass_oe_o, fail_n_o, fail_oe_o, ready_n_o, ready_oe_o;
  logic run_start_o, run_done_i = 1'b0, run_pass_i = 1'b0, eng_pass = 1'b1;
  int eng_wait = 8, eng_cnt = 0, cycles = 0, failures = 0, tests_run = 0;
  // pins as the far side sees them, pull-ups when undriven
  wire logic pass_pin  = pass_oe_o ? pass_n_o : 1'b1;
  wire logic fail_pin  = fail_oe_o ? fail_n_o : 1'b1;
  wire logic ready_pin = ready_oe_o ? ready_n_o : 1'b1;
  plsp_row_t rows [5] = '{'{1, 1, 1, 1, 0, 1}, '{1, 1, 0, 2, 1, 0},
    '{0, 1, 1, 2, 1, 0}, '{1, 0, 1, 2, 1, 0}, '{1, 1, 1, 3, 0, 1}};

  plsp_port #(.TICK_CYCLES(10)) i_dut (.clock_i, .rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .launch_n_i, .sense_n_i,
    .io_supply_ref_i, .pass_n_o, .pass_oe_o, .fail_n_o, .fail_oe_o,
    .ready_n_o, .ready_oe_o, .aux_supply_out_o, .run_start_o, .run_done_i,
    .run_pass_i);
  plsp_ctl_model ctl (.clock_i, .ready_pin_i(ready_pin),
    .launch_n_o(launch_n_i), .sense_n_o(sense_n_i));

  // clock
  initial begin
    forever #10 clock_i = !clock_i;
  end

  // engine: done pulse eng_wait edges after start
  always @(posedge clock_i) begin
    run_done_i <= (eng_cnt == 1);
    run_pass_i <= eng_pass;
    eng_cnt <= run_start_o ? eng_wait : (eng_cnt != 0 ? eng_cnt - 1 : 0);
  end

  // hang guard, well above the expected few hundred cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one single ahb-lite transfer at the current hsize_i; read data taken at its last edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    @(posedge clock_i);
    while (!hreadyout_o) @(posedge clock_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clock_i);
    while (!hreadyout_o) @(posedge clock_i);
    q = hrdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("register", q, e);
    chk("hresp", hresp_o, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    // row table: allow bit, sense, result, run count and pins
    foreach (rows[i]) begin
      ahb(1'b1, 8'h00, {30'h0, 1'b1, rows[i].allow});
      ctl.select(rows[i].on);
      eng_pass = rows[i].pass;
      repeat (6) @(posedge clock_i); // synchroniser settles
      ctl.launch(3);
      chk("pass pin", pass_pin, rows[i].pass_n);
      chk("fail pin", fail_pin, rows[i].fail_n);
      chk("ready pin", ready_pin, 1'b0);
      rd_chk(8'h0C, rows[i].runs);
    end
    // launch poked while busy is dropped
    eng_wait = 40;
    eng_pass = 1'b0;
    fork
      ctl.launch(3);
      begin
        repeat (20) @(posedge clock_i);
        ctl.pulse(3);
      end
    join
    repeat (20) @(posedge clock_i);
    rd_chk(8'h0C, 32'h4);
    chk("fail pin", fail_pin, 1'b0);
    // result ages out after two ticks
    eng_wait = 8;
    eng_pass = 1'b1;
    ahb(1'b1, 8'h08, 32'h2);
    ctl.launch(2);
    chk("pass pin", pass_pin, 1'b0);
    repeat (45) @(posedge clock_i);
    chk("pass pin", pass_pin, 1'b1);
    chk("fail pin", fail_pin, 1'b1);
    // idle, no result shown, port active, supply present
    rd_chk(8'h04, 32'h19);
    // byte size and deselected transfers leave the timeout alone
    hsize_i <= 3'h0;
    ahb(1'b1, 8'h08, 32'h5);
    hsize_i <= 3'h2;
    hsel_i <= 1'b0;
    ahb(1'b1, 8'h08, 32'h7);
    hsel_i <= 1'b1;
    rd_chk(8'h08, 32'h2);
    // aux supply off, launching still allowed
    ahb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("aux out", aux_supply_out_o, 1'b0);
    ahb(1'b1, 8'h0C, 32'h0);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h10, 32'h0);
    // supply removed: pins undriven
    io_supply_ref_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk("oe", {pass_oe_o, fail_oe_o, ready_oe_o}, 3'b000);
    io_supply_ref_i <= 1'b1;
    // hard reset in mid-run
    eng_wait = 40;
    fork
      ctl.launch(3);
      begin
        repeat (15) @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("status", {pass_n_o, fail_n_o, ready_n_o}, 3'b110);
      end
    join
    rd_chk(8'h00, 32'h2);
    rd_chk(8'h08, 32'h0);
    chk("aux out", aux_supply_out_o, 1'b1);
    tally_and_finish();
  end
endmodule
